// File: rtl/acsc_top.sv
// conversion sequencing, clock selection and serial readout of the converter
// Summary of operation
// - low-power pin low halts oscillator and analog, entering low-power state
// - reset holds logic; release starts analog startup; ready falls when done
// - low request starts conversion; requests during a running conversion ignored
// - finished conversion loads result into port register and drops ready
// - request still low when ready falls starts next conversion
// - master clock pin tied low selects on-chip oscillator
// - master clock pin held high stops all clocks and oscillator
// - toggling master clock pin runs internal circuitry from external clock
// - result shifted out msb first, advancing on shift clock rising edges
// - serial data output high impedance while chip select high
// - self-clocked mode drives shift clock derived from active master clock
// - self-clocked shift clock output high impedance while chip select high
// - ready stays high during conversion unless a previous word is still unread, falls when word available
// - ready returns high once every result bit shifted out
// - unread with chip select high: ready rises two master clocks before load
// - external mode, select low, unread: ready rises two master clocks early
// - port role high makes port master; low makes it slave
// - polarity high codes two's complement; low codes straight binary
`timescale 1ns/1ps
module acsc_top (
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic sleep_n,
   input  wire logic begin_sample_n,
   input  wire logic master_clock,
   input  wire logic port_role_select,
   input  wire logic polarity_select,
   input  wire logic chip_select_n,
   input  wire logic shift_clock_in,
   output logic      shift_clock_out,
   output logic      shift_clock_oe_n,
   output logic      serial_out,
   output logic      serial_out_oe_n,
   output logic      ready_n,
   output logic      low_power,
   output logic      osc_running,
   output logic      analog_on,
   output logic      self_clocked_mode,
   output logic      external_clocked_mode
);
   localparam int unsigned W = acsc_pkg::WORD_BITS;

   // pin synchronisers
   logic [2:0] s_mclk;
   logic [2:0] s_sclk;
   logic [2:0] s_begin_sample_n;
   logic [2:0] s_cs;
   logic [2:0] s_sleep;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_mclk  <= 3'h0;
         s_sclk  <= 3'h0;
         s_begin_sample_n  <= 3'h7;
         s_cs    <= 3'h7;
         s_sleep <= 3'h7;
      end else begin
         s_mclk  <= {s_mclk[1:0], master_clock};
         s_sclk  <= {s_sclk[1:0], shift_clock_in};
         s_begin_sample_n  <= {s_begin_sample_n[1:0], begin_sample_n};
         s_cs    <= {s_cs[1:0], chip_select_n};
         s_sleep <= {s_sleep[1:0], sleep_n};
      end
   end

   logic mclk_f_q;
   logic sclk_f_q;
   logic begin_sample_n_n_q;
   logic cs_n_q;
   logic sleep_n_q;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mclk_f_q  <= 1'b0;
         sclk_f_q  <= 1'b0;
         begin_sample_n_n_q  <= 1'b1;
         cs_n_q    <= 1'b1;
         sleep_n_q <= 1'b1;
      end else begin
         if (s_mclk[2] == s_mclk[1]) mclk_f_q <= s_mclk[2];
         if (s_sclk[2] == s_sclk[1]) sclk_f_q <= s_sclk[2];
         if (s_begin_sample_n[2] == s_begin_sample_n[1]) begin_sample_n_n_q <= s_begin_sample_n[2];
         if (s_cs[2] == s_cs[1]) cs_n_q <= s_cs[2];
         if (s_sleep[2] == s_sleep[1]) sleep_n_q <= s_sleep[2];
      end
   end

   logic mclk_rise;
   logic sclk_rise;
   assign mclk_rise = (s_mclk[2] == s_mclk[1]) && s_mclk[2] && !mclk_f_q;
   assign sclk_rise = (s_sclk[2] == s_sclk[1]) && s_sclk[2] && !sclk_f_q;

   // master clock source detection
   logic [7:0]                  idle_cnt_q;
   acsc_pkg::acsc_clk_src_t     src_q;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         idle_cnt_q <= 8'h00;
         src_q      <= acsc_pkg::ACSC_CK_OSC;
      end else if (mclk_rise) begin
         idle_cnt_q <= 8'h00;
         src_q      <= acsc_pkg::ACSC_CK_EXT;
      end else if (idle_cnt_q != 8'hFF) begin
         idle_cnt_q <= idle_cnt_q + 8'h01;
      end else if (mclk_f_q) begin
         src_q <= acsc_pkg::ACSC_CK_STOP;
      end else begin
         src_q <= acsc_pkg::ACSC_CK_OSC;
      end
   end

   // internal oscillator divider
   logic [3:0] osc_cnt_q;
   logic       osc_tick;
   logic       osc_en;
   assign osc_en   = sleep_n_q && (src_q == acsc_pkg::ACSC_CK_OSC);
   assign osc_tick = osc_en && (osc_cnt_q == 4'(acsc_pkg::OSC_DIV - 1));
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         osc_cnt_q <= 4'h0;
      end else if (!osc_en || osc_tick) begin
         osc_cnt_q <= 4'h0;
      end else begin
         osc_cnt_q <= osc_cnt_q + 4'h1;
      end
   end

   // one enable per internal master clock cycle
   logic mtick;
   always_comb begin
      unique case (src_q)
         acsc_pkg::ACSC_CK_EXT: mtick = mclk_rise && sleep_n_q;
         acsc_pkg::ACSC_CK_OSC: mtick = osc_tick;
         default:               mtick = 1'b0;
      endcase
   end

   // conversion sequencer
   acsc_pkg::acsc_state_t st_q;
   logic [11:0]           cnt_q;
   logic [23:0]           raw_q;
   logic                  load;
   logic                  early;
   logic                  unread_q;
   logic                  fifo_in_ready;
   assign load  = mtick && (st_q == acsc_pkg::ACSC_ST_CONVERT) && (cnt_q == 12'h000)
                  && fifo_in_ready;
   assign early = mtick && (st_q == acsc_pkg::ACSC_ST_CONVERT)
                  && (cnt_q == 12'(acsc_pkg::EARLY_MCLKS));
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_q  <= acsc_pkg::ACSC_ST_STARTUP;
         cnt_q <= 12'(acsc_pkg::START_MCLKS);
         raw_q <= acsc_pkg::RESULT_SEED;
      end else if (!sleep_n_q) begin
         st_q <= acsc_pkg::ACSC_ST_SLEEP;
      end else if (mtick) begin
         unique case (st_q)
            acsc_pkg::ACSC_ST_SLEEP: begin
               st_q  <= acsc_pkg::ACSC_ST_STARTUP;
               cnt_q <= 12'(acsc_pkg::START_MCLKS);
            end
            acsc_pkg::ACSC_ST_STARTUP: begin
               if (cnt_q == 12'h000) begin
                  st_q <= acsc_pkg::ACSC_ST_HOLD;
               end else begin
                  cnt_q <= cnt_q - 12'h001;
               end
            end
            acsc_pkg::ACSC_ST_IDLE: begin
               if (!begin_sample_n_n_q) begin
                  st_q  <= acsc_pkg::ACSC_ST_CONVERT;
                  cnt_q <= 12'(acsc_pkg::BEGIN_SAMPLE_N_MCLKS - 1);
               end
            end
            acsc_pkg::ACSC_ST_CONVERT: begin
               if (cnt_q != 12'h000) begin
                  cnt_q <= cnt_q - 12'h001;
               end else if (fifo_in_ready) begin
                  raw_q <= raw_q + acsc_pkg::RESULT_STEP;
                  st_q  <= acsc_pkg::ACSC_ST_HOLD;
               end
            end
            acsc_pkg::ACSC_ST_HOLD: begin
               if (!begin_sample_n_n_q) begin
                  st_q  <= acsc_pkg::ACSC_ST_CONVERT;
                  cnt_q <= 12'(acsc_pkg::BEGIN_SAMPLE_N_MCLKS - 1);
               end else begin
                  st_q <= acsc_pkg::ACSC_ST_IDLE;
               end
            end
            default: st_q <= acsc_pkg::ACSC_ST_STARTUP;
         endcase
      end
   end

   // result fifo, the shifter drains it
   logic [23:0] coded;
   logic [23:0] fifo_out;
   logic        fifo_out_valid;
   logic        take;
   logic        busy_q;
   logic        flush_stale;
   assign coded = polarity_select ? (raw_q ^ acsc_pkg::SIGN_FLIP) : raw_q;
   assign take  = fifo_out_valid && !busy_q;
   assign flush_stale = early && unread_q && !busy_q;

   acsc_fifo #(
      .WIDTH (W),
      .DEPTH (acsc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .resetn    (resetn),
      .flush     (flush_stale),
      .in_data   (coded),
      .in_valid  (load),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_out_valid),
      .out_ready (take)
   );

   // serial shifter
   logic [23:0] sh_q;
   logic [4:0]  bit_q;
   logic        master;
   logic [1:0]  div_q;
   logic        sck_q;
   logic        sck_adv;
   logic        started_q;
   assign master  = port_role_select;
   assign sck_adv = master ? (mtick && !cs_n_q && busy_q && (div_q == 2'h3) && !sck_q)
                           : (sclk_rise && !cs_n_q && busy_q);
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         div_q <= 2'h0;
         sck_q <= 1'b0;
      end else if (!master || cs_n_q || !busy_q) begin
         div_q <= 2'h0;
         sck_q <= 1'b0;
      end else if (mtick) begin
         div_q <= div_q + 2'h1;
         if (div_q == 2'h3) sck_q <= !sck_q;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sh_q      <= 24'h000000;
         bit_q     <= 5'h00;
         busy_q    <= 1'b0;
         unread_q  <= 1'b0;
         started_q <= 1'b0;
      end else if (take) begin
         sh_q      <= fifo_out;
         bit_q     <= 5'(W);
         busy_q    <= 1'b1;
         unread_q  <= 1'b1;
         started_q <= 1'b0;
      end else if (sck_adv) begin
         started_q <= 1'b1;
         unread_q  <= 1'b0;
         if (started_q || !master) begin
            sh_q <= {sh_q[22:0], 1'b0};
         end
         if (bit_q == 5'h01) begin
            busy_q <= 1'b0;
         end
         bit_q <= bit_q - 5'h01;
      end else if (early && unread_q) begin
         busy_q   <= 1'b0;
         unread_q <= 1'b0;
      end
   end

   // ready low once startup ends, until a conversion starts
   logic boot_q;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         boot_q <= 1'b0;
      end else if (!sleep_n_q || st_q == acsc_pkg::ACSC_ST_CONVERT) begin
         boot_q <= 1'b0;
      end else if (mtick && st_q == acsc_pkg::ACSC_ST_STARTUP && cnt_q == 12'h000) begin
         boot_q <= 1'b1;
      end
   end

   // pins
   logic rdy_d;
   assign rdy_d = !((busy_q && (st_q != acsc_pkg::ACSC_ST_STARTUP)) || boot_q);
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ready_n               <= 1'b1;
         serial_out            <= 1'b0;
         serial_out_oe_n       <= 1'b1;
         shift_clock_out       <= 1'b0;
         shift_clock_oe_n      <= 1'b1;
         low_power             <= 1'b0;
         osc_running           <= 1'b0;
         analog_on             <= 1'b0;
         self_clocked_mode     <= 1'b0;
         external_clocked_mode <= 1'b0;
      end else begin
         ready_n               <= rdy_d;
         serial_out            <= sh_q[23];
         serial_out_oe_n       <= cs_n_q;
         shift_clock_out       <= sck_q;
         shift_clock_oe_n      <= cs_n_q || !master;
         low_power             <= !sleep_n_q;
         osc_running           <= osc_en;
         analog_on             <= sleep_n_q && (src_q != acsc_pkg::ACSC_CK_STOP);
         self_clocked_mode     <= master;
         external_clocked_mode <= !master;
      end
   end
endmodule

// File: rtl/acsc_pkg.sv
// constants for the converter control and serial readout block
package acsc_pkg;
   localparam int unsigned WORD_BITS      = 24;
   localparam int unsigned FIFO_DEPTH     = 4;
   localparam int unsigned CLK_HZ         = 40000000;
   localparam int unsigned OSC_DIV        = 5;
   localparam int unsigned SCLK_DIV       = 4;
   localparam int unsigned BEGIN_SAMPLE_N_MCLKS     = 1600;
   localparam int unsigned START_MCLKS    = 64;
   localparam int unsigned EARLY_MCLKS    = 2;
   localparam int unsigned SYNC_STAGES    = 3;
   localparam logic [23:0] RESULT_SEED    = 24'h5A5A5A;
   localparam logic [23:0] RESULT_STEP    = 24'h012345;
   localparam logic [23:0] SIGN_FLIP      = 24'h800000;

   typedef enum logic [2:0] {
      ACSC_ST_STARTUP = 3'b000,
      ACSC_ST_IDLE    = 3'b001,
      ACSC_ST_CONVERT = 3'b010,
      ACSC_ST_HOLD    = 3'b011,
      ACSC_ST_SLEEP   = 3'b100
   } acsc_state_t;

   typedef enum logic [1:0] {
      ACSC_CK_OSC  = 2'b00,
      ACSC_CK_STOP = 2'b01,
      ACSC_CK_EXT  = 2'b10
   } acsc_clk_src_t;
endpackage

// File: rtl/acsc_fifo.sv
// small result word fifo with valid and ready on both sides
`timescale 1ns/1ps
module acsc_fifo #(
   parameter int unsigned WIDTH = 24,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic             clock,
   input  wire logic             resetn,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// File: testbench/acsc_top_assertions.sv
// concurrent checks on the converter control block ports
`timescale 1ns/1ps
module acsc_chk (
   input wire logic clock,
   input wire logic resetn,
   input wire logic sleep_n,
   input wire logic master_clock,
   input wire logic port_role_select,
   input wire logic chip_select_n,
   input wire logic shift_clock_oe_n,
   input wire logic serial_out_oe_n,
   input wire logic ready_n,
   input wire logic low_power,
   input wire logic osc_running,
   input wire logic analog_on,
   input wire logic self_clocked_mode,
   input wire logic external_clocked_mode
);
   logic [8:0] run_q;
   logic       mclk_q;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   // cycles the master clock pin has kept one level
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         run_q <= 9'h000;
      end else if (master_clock != mclk_q) begin
         run_q <= 9'h000;
      end else if (run_q != 9'h12C) begin
         run_q <= run_q + 9'h001;
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mclk_q <= 1'b0;
      end else begin
         mclk_q <= master_clock;
      end
   end
   a_data_hiz_cs: assert property (chip_select_n [*6] |-> serial_out_oe_n)
      else $error("data output driven with select high");
   a_sclk_hiz_cs: assert property (chip_select_n [*6] |-> shift_clock_oe_n)
      else $error("shift clock driven with select high");
   a_master_role: assert property
      (port_role_select [*3] |-> self_clocked_mode && !external_clocked_mode)
      else $error("master role not reflected");
   a_slave_role: assert property
      (!port_role_select [*3] |-> external_clocked_mode && shift_clock_oe_n)
      else $error("slave role drives shift clock");
   a_sleep_power_off: assert property
      (!sleep_n [*6] |-> low_power && !osc_running && !analog_on)
      else $error("low power state not entered");
   a_stop_osc_off: assert property (run_q == 9'h12C && master_clock |-> !osc_running)
      else $error("oscillator runs with clock pin high");
   a_osc_on_low: assert property
      ((run_q == 9'h12C && !master_clock && sleep_n) [*8] |-> osc_running)
      else $error("oscillator idle with clock pin low");
   a_ready_early: assert property ($fell(ready_n) |-> $past(ready_n, 8))
      else $error("ready not high before new word");
   cover property ($fell(ready_n));
   cover property ($rose(ready_n));
   cover property (!shift_clock_oe_n);
endmodule
bind acsc_top acsc_chk u_chk (.clock, .resetn, .sleep_n, .master_clock, .port_role_select,
   .chip_select_n, .shift_clock_oe_n, .serial_out_oe_n, .ready_n, .low_power, .osc_running,
   .analog_on, .self_clocked_mode, .external_clocked_mode);

// File: testbench/acsc_host_model.sv
// host side model reading result words from the serial port
`timescale 1ns/1ps
module acsc_host_model (
   input  wire logic clock,
   input  wire logic port_role_select,
   input  wire logic serial_line,
   input  wire logic shift_clock_out,
   output logic      chip_select_n,
   output logic      shift_clock_in
);
   initial begin
      chip_select_n = 1'b1;
      shift_clock_in = 1'b0;
   end
   // one framed read, shift clock kept inside the frame, select low 8 clocks before and after
   task automatic read_word(output logic [23:0] w);
      @(posedge clock);
      #2 chip_select_n = 1'b0;
      repeat (8) @(posedge clock);
      for (int i = 23; i >= 0; i--) begin
         if (port_role_select) begin
            @(negedge shift_clock_out);
         end else begin
            #100 shift_clock_in = 1'b1;
         end
         w[i] = serial_line;
         #100 shift_clock_in = 1'b0;
      end
      repeat (8) @(posedge clock);
      #2 chip_select_n = 1'b1;
   endtask
endmodule

// File: testbench/testbench.sv
// top level bench for the converter control block
`timescale 1ns/1ps
module testbench;
   logic        clock;
   logic        resetn;
   logic        sleep_n;
   logic        begin_sample_n;
   logic        master_clock;
   logic        port_role_select;
   logic        polarity_select;
   logic        chip_select_n;
   logic        shift_clock_in;
   logic        shift_clock_out;
   logic        shift_clock_oe_n;
   logic        serial_out;
   logic        serial_out_oe_n;
   logic        ready_n;
   logic        low_power;
   logic        osc_running;
   logic        analog_on;
   logic        self_clocked_mode;
   logic        external_clocked_mode;
   logic        last_q = 1'b0;
   logic        serial_line;
   logic        ext_en = 1'b0;
   logic [23:0] w [4];
   int          err_total = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   int          n;
   acsc_top dut (.clock, .resetn, .sleep_n, .begin_sample_n, .master_clock, .port_role_select,
      .polarity_select, .chip_select_n, .shift_clock_in, .shift_clock_out, .shift_clock_oe_n,
      .serial_out, .serial_out_oe_n, .ready_n, .low_power, .osc_running, .analog_on,
      .self_clocked_mode, .external_clocked_mode);
   acsc_host_model host (.clock, .port_role_select, .serial_line, .shift_clock_out,
      .chip_select_n, .shift_clock_in);
   // released data line shows the inverse of its last bit
   always @(posedge clock) begin
      if (!serial_out_oe_n)
         last_q <= serial_out;
   end
   assign serial_line = serial_out_oe_n ? ~last_q : serial_out;
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always #50 if (ext_en) master_clock = ~master_clock;
   always @(posedge clock) begin
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_ready(input logic v, input int lim);
      n = 0;
      while (ready_n !== v && n < lim) begin
         @(posedge clock);
         #2;
         n++;
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      resetn = 1'b0;
      sleep_n = 1'b1;
      begin_sample_n = 1'b1;
      master_clock = 1'b0;
      port_role_select = 1'b0;
      polarity_select = 1'b0;
      repeat (20) @(posedge clock);
      #2;
      check(24'(ready_n), 24'h000001);
      check(24'({serial_out_oe_n, shift_clock_oe_n}), 24'h000003);
      resetn = 1'b1;
      repeat (400) @(posedge clock);
      #2;
      check(24'(ready_n), 24'h000000);
      begin_sample_n = 1'b0;
      repeat (20) @(posedge clock);
      #2;
      check(24'(ready_n), 24'h000001);
      for (int i = 0; i < 3; i++) begin
         polarity_select = (i == 1);
         begin_sample_n = (i == 2);
         wait_ready(1'b0, 9000);
         check(24'(ready_n), 24'h000000);
         host.read_word(w[i]);
         repeat (4) @(posedge clock);
         #2;
         check(24'(ready_n), 24'h000001);
      end
      check(w[1] ^ acsc_pkg::SIGN_FLIP, w[0] + acsc_pkg::RESULT_STEP);
      check(w[2], w[0] + acsc_pkg::RESULT_STEP + acsc_pkg::RESULT_STEP);
      wait_ready(1'b0, 9000);
      check(24'(ready_n), 24'h000001);
      $display("test slave reads done");
      begin_sample_n = 1'b0;
      wait_ready(1'b0, 9000);
      wait_ready(1'b1, 9000);
      check(24'(ready_n), 24'h000001);
      wait_ready(1'b0, 40);
      check(24'(n > 5 && n < 15), 24'h000001);
      begin_sample_n = 1'b1;
      port_role_select = 1'b1;
      $display("test unread overwrite done");
      wait_ready(1'b1, 9000);
      wait_ready(1'b0, 40);
      check(24'(self_clocked_mode), 24'h000001);
      host.read_word(w[3]);
      check(w[3], 24'(w[0] + 5 * acsc_pkg::RESULT_STEP));
      repeat (4) @(posedge clock);
      #2;
      check(24'(ready_n), 24'h000001);
      port_role_select = 1'b0;
      $display("test master read done");
      sleep_n = 1'b0;
      repeat (10) @(posedge clock);
      #2;
      check(24'({low_power, osc_running, analog_on}), 24'h000004);
      sleep_n = 1'b1;
      master_clock = 1'b1;
      repeat (300) @(posedge clock);
      #2;
      check(24'(osc_running), 24'h000000);
      ext_en = 1'b1;
      repeat (1000) @(posedge clock);
      #2 begin_sample_n = 1'b0;
      repeat (20) @(posedge clock);
      #2;
      check(24'(ready_n), 24'h000001);
      wait_ready(1'b0, 9000);
      check(24'(ready_n), 24'h000000);
      begin_sample_n = 1'b1;
      $display("test power and clock modes done");
      stop_test();
   end
endmodule
